//--- core/fcks_regs.sv
// Behaviour
// - Wait-state code sets flash access latency
// - Prefetch enable bit, read-only prefetch state bit
// - Main unlock key write-only, reads zero
// - Option unlock key write-only, reads zero
// - Busy flag high during program or erase
// - Program onto non-erased halfword sets program error
// - Program onto protected address sets protect error
// - Operation end sets done flag
// - Reset clears status and access control
// - Lock only set; key sequence unlocks
// - Error interrupt when enabled and error flagged
// - Done interrupt when enabled and done flagged
module fcks_regs
   import fcks_pkg::*;
#(
   parameter logic [31:0] KEY_FIRST  = 32'h1234_5678,
   parameter logic [31:0] KEY_SECOND = 32'h9ABC_DEF0
) (
   // Clock and reset
   input  wire logic          clk,
   input  wire logic          sys_rst,
   // Register port
   input  wire logic [7:0]    reg_addr,
   input  wire logic [31:0]   reg_wdata,
   input  wire logic          reg_we,
   input  wire logic          reg_re,
   output logic      [31:0]   reg_rdata,
   // Flash array
   output fcks_arr_req_s      arr_req,
   input  wire fcks_arr_rsp_s arr_rsp,
   // Program requests from the memory bus
   input  wire logic          prog_req,
   input  wire logic [31:0]   prog_addr,
   input  wire logic [15:0]   prog_data,
   // Option and protection state
   input  wire logic [31:0]   opt_state,
   input  wire logic [31:0]   wrprot_state,
   // Access control and events
   output logic      [2:0]    wait_state_sel,
   output logic               prefetch_enable,
   output logic               prefetch_state,
   output logic               option_load,
   output logic               flash_irq
);

   fcks_state_e state_q;
   logic        op_in_progress;
   logic        lock_q;
   logic        key_stage_q;
   logic        opt_stage_q;
   logic        obwen_q;
   logic        pg_q;
   logic        per_q;
   logic        mer_q;
   logic        obp_q;
   logic        obe_q;
   logic        start_q;
   logic        error_irq_enable_q;
   logic        done_irq_enable_q;
   logic [31:0] target_q;
   logic [2:0]  irq_mask_q;
   logic [31:0] rdata_q;
   logic [31:0] rd_mux;

   logic wr_access;
   logic wr_key;
   logic wr_optkey;
   logic wr_status;
   logic wr_ctrl;
   logic wr_target;
   logic wr_mask;
   logic rd_irq;
   logic ctrl_open;
   logic prog_ok;
   logic prog_go;
   logic erase_go;
   logic set_perr;
   logic set_werr;
   logic set_done;

   // Flag order inside the sticky cells: {done, protect, program}
   logic [2:0] flag_set;
   logic [2:0] flag_clr;
   logic [2:0] flags;
   logic [2:0] irq_clr;
   logic [2:0] irq_stat;
   logic       program_error_flag;
   logic       protect_error_flag;
   logic       op_done_flag;

   assign wr_access = reg_we && (reg_addr == OFF_ACCESS);
   assign wr_key    = reg_we && (reg_addr == OFF_MAIN_KEY);
   assign wr_optkey = reg_we && (reg_addr == OFF_OPT_KEY);
   assign wr_status = reg_we && (reg_addr == OFF_STATUS);
   assign wr_ctrl   = reg_we && (reg_addr == OFF_OP_CTRL);
   assign wr_target = reg_we && (reg_addr == OFF_TARGET);
   assign wr_mask   = reg_we && (reg_addr == OFF_IRQ_MASK);
   assign rd_irq    = reg_re && (reg_addr == OFF_IRQ_STAT);
   assign ctrl_open = !lock_q;

   // Access control
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wait_state_sel  <= ACCESS_RST[WS_MSB:WS_LSB];
         prefetch_enable <= ACCESS_RST[PREFETCH_ENABLE_BIT];
      end else if (wr_access) begin
         // Reserved codes are stored as written
         wait_state_sel  <= reg_wdata[WS_MSB:WS_LSB];
         prefetch_enable <= reg_wdata[PREFETCH_ENABLE_BIT];
      end
   end

   // Prefetch buffer reports enabled one cycle after the request
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         prefetch_state <= ACCESS_RST[PBST_BIT];
      end else begin
         prefetch_state <= prefetch_enable;
      end
   end

   // Main unlock: two keys in order; a wrong word restarts the sequence
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         lock_q      <= LOCK_RST;
         key_stage_q <= 1'b0;
      end else if (wr_ctrl && reg_wdata[LOCK_BIT]) begin
         lock_q      <= 1'b1;
         key_stage_q <= 1'b0;
      end else if (wr_key && lock_q) begin
         if (!key_stage_q && reg_wdata == KEY_FIRST) begin
            key_stage_q <= 1'b1;
         end else if (key_stage_q && reg_wdata == KEY_SECOND) begin
            lock_q      <= 1'b0;
            key_stage_q <= 1'b0;
         end else begin
            key_stage_q <= 1'b0;
         end
      end
   end

   // Option unlock only counts while the main lock is open
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         obwen_q     <= 1'b0;
         opt_stage_q <= 1'b0;
      end else if (lock_q || (wr_ctrl && reg_wdata[LOCK_BIT])) begin
         obwen_q     <= 1'b0;
         opt_stage_q <= 1'b0;
      end else if (wr_ctrl && !reg_wdata[OBWEN_BIT]) begin
         obwen_q <= 1'b0;
      end else if (wr_optkey) begin
         if (!opt_stage_q && reg_wdata == KEY_FIRST) begin
            opt_stage_q <= 1'b1;
         end else if (opt_stage_q && reg_wdata == KEY_SECOND) begin
            obwen_q     <= 1'b1;
            opt_stage_q <= 1'b0;
         end else begin
            opt_stage_q <= 1'b0;
         end
      end
   end

   // Operation control bits, writable only while unlocked
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pg_q    <= 1'b0;
         per_q   <= 1'b0;
         mer_q   <= 1'b0;
         obp_q   <= 1'b0;
         obe_q   <= 1'b0;
         error_irq_enable_q <= 1'b0;
         done_irq_enable_q  <= 1'b0;
      end else if (wr_ctrl && ctrl_open) begin
         pg_q    <= reg_wdata[PG_BIT];
         per_q   <= reg_wdata[PER_BIT];
         mer_q   <= reg_wdata[MER_BIT];
         obp_q   <= reg_wdata[OBP_BIT];
         obe_q   <= reg_wdata[OBE_BIT];
         error_irq_enable_q <= reg_wdata[ERROR_IRQ_ENABLE_BIT];
         done_irq_enable_q  <= reg_wdata[DONE_IRQ_ENABLE_BIT];
      end
   end

   // Program and erase launch decisions
   assign prog_ok  = prog_req && (state_q == ST_IDLE)
                     && (pg_q || (obp_q && obwen_q));
   assign set_werr = prog_ok && arr_rsp.wp_hit;
   assign set_perr = prog_ok && !arr_rsp.wp_hit
                     && (arr_rsp.old_data != ERASED_HALF);
   assign prog_go  = prog_ok && !arr_rsp.wp_hit
                     && (arr_rsp.old_data == ERASED_HALF);
   assign erase_go = wr_ctrl && ctrl_open && reg_wdata[STA_BIT]
                     && (state_q == ST_IDLE)
                     && (reg_wdata[PER_BIT] || reg_wdata[MER_BIT]
                         || (reg_wdata[OBE_BIT] && obwen_q));
   assign set_done = (state_q != ST_IDLE) && arr_rsp.done;

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_q <= ST_IDLE;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               if (prog_go) begin
                  state_q <= ST_PROG;
               end else if (erase_go) begin
                  state_q <= ST_ERASE;
               end
            end
            ST_PROG, ST_ERASE: begin
               // Busy drops in the cycle the done flag is set
               if (arr_rsp.done) begin
                  state_q <= ST_IDLE;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   assign op_in_progress = (state_q != ST_IDLE);

   // Start bit is software-set and cleared when the operation ends
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         start_q <= 1'b0;
      end else if (erase_go) begin
         start_q <= 1'b1;
      end else if (set_done) begin
         start_q <= 1'b0;
      end
   end

   // Target address follows the halfword being programmed
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         target_q <= TARGET_RST;
      end else if (prog_go) begin
         target_q <= prog_addr;
      end else if (wr_target && ctrl_open) begin
         target_q <= reg_wdata;
      end
   end

   // Array launch strobes are one-cycle registered pulses
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         arr_req <= '0;
      end else begin
         arr_req.prog       <= prog_go;
         arr_req.erase_page <= erase_go && reg_wdata[PER_BIT];
         arr_req.erase_mass <= erase_go && reg_wdata[MER_BIT];
         if (prog_go) begin
            arr_req.opt_area <= obp_q;
            arr_req.addr     <= prog_addr;
            arr_req.wdata    <= prog_data;
         end else if (erase_go) begin
            arr_req.opt_area <= reg_wdata[OBE_BIT];
            arr_req.addr     <= target_q;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         option_load <= 1'b0;
      end else begin
         option_load <= wr_ctrl && ctrl_open && reg_wdata[OBLOAD_BIT];
      end
   end

   // Status flags: set by hardware, write one to clear
   assign flag_set = {set_done, set_werr, set_perr};
   assign flag_clr = wr_status ? {reg_wdata[DONE_BIT], reg_wdata[WERR_BIT],
                                  reg_wdata[PERR_BIT]} : 3'h0;

   fcks_sticky #(.W(3)) u_flags (
      .clk     (clk),
      .sys_rst (sys_rst),
      .set     (flag_set),
      .clr     (flag_clr),
      .q       (flags)
   );

   assign program_error_flag = flags[0];
   assign protect_error_flag = flags[1];
   assign op_done_flag       = flags[2];

   // Event status for the interrupt line, cleared by reading it
   assign irq_clr = rd_irq ? 3'h7 : 3'h0;

   fcks_sticky #(.W(3)) u_irq_stat (
      .clk     (clk),
      .sys_rst (sys_rst),
      .set     (flag_set),
      .clr     (irq_clr),
      .q       (irq_stat)
   );

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         irq_mask_q <= 3'h0;
      end else if (wr_mask) begin
         irq_mask_q <= {reg_wdata[DONE_BIT], reg_wdata[WERR_BIT],
                        reg_wdata[PERR_BIT]};
      end
   end

   assign flash_irq =
      (error_irq_enable_q && (program_error_flag || protect_error_flag))
      || (done_irq_enable_q && op_done_flag)
      || (|(irq_stat & irq_mask_q));

   // Read mux; key registers and unmapped offsets read zero
   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (reg_addr)
         OFF_ACCESS: begin
            rd_mux[WS_MSB:WS_LSB] = wait_state_sel;
            rd_mux[PREFETCH_ENABLE_BIT]      = prefetch_enable;
            rd_mux[PBST_BIT]      = prefetch_state;
         end
         OFF_STATUS: begin
            rd_mux[BUSY_BIT] = op_in_progress;
            rd_mux[PERR_BIT] = program_error_flag;
            rd_mux[WERR_BIT] = protect_error_flag;
            rd_mux[DONE_BIT] = op_done_flag;
         end
         OFF_OP_CTRL: begin
            rd_mux[PG_BIT]    = pg_q;
            rd_mux[PER_BIT]   = per_q;
            rd_mux[MER_BIT]   = mer_q;
            rd_mux[OBP_BIT]   = obp_q;
            rd_mux[OBE_BIT]   = obe_q;
            rd_mux[STA_BIT]   = start_q;
            rd_mux[LOCK_BIT]  = lock_q;
            rd_mux[OBWEN_BIT] = obwen_q;
            rd_mux[ERROR_IRQ_ENABLE_BIT] = error_irq_enable_q;
            rd_mux[DONE_IRQ_ENABLE_BIT]  = done_irq_enable_q;
         end
         OFF_OPT_STATE: rd_mux = opt_state;
         OFF_WRPROT:    rd_mux = wrprot_state;
         OFF_IRQ_STAT: begin
            rd_mux[PERR_BIT] = irq_stat[0];
            rd_mux[WERR_BIT] = irq_stat[1];
            rd_mux[DONE_BIT] = irq_stat[2];
         end
         OFF_IRQ_MASK: begin
            rd_mux[PERR_BIT] = irq_mask_q[0];
            rd_mux[WERR_BIT] = irq_mask_q[1];
            rd_mux[DONE_BIT] = irq_mask_q[2];
         end
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // Read data stand only in the cycle after the strobe
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rdata_q <= 32'h0000_0000;
      end else begin
         rdata_q <= reg_re ? rd_mux : 32'h0000_0000;
      end
   end

   assign reg_rdata = rdata_q;

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   a_ws_follows_write: assert property (
      wr_access |=> wait_state_sel == $past(reg_wdata[WS_MSB:WS_LSB]))
      else $error("wait state code not taken from write");
   a_prefetch_state_lag: assert property (
      $rose(prefetch_enable) |=> prefetch_state)
      else $error("prefetch state did not follow enable");
   a_key_reads_zero: assert property (
      reg_re && reg_addr == OFF_MAIN_KEY |=> reg_rdata == 32'h0000_0000)
      else $error("main key read not zero");
   a_optkey_reads_zero: assert property (
      reg_re && reg_addr == OFF_OPT_KEY |=> reg_rdata == 32'h0000_0000)
      else $error("option key read not zero");
   a_busy_on_launch: assert property (
      (prog_go || erase_go) |=> op_in_progress && (arr_req.prog
         || arr_req.erase_page || arr_req.erase_mass || arr_req.opt_area))
      else $error("busy or launch missing after start");
   a_perr_sets: assert property (
      set_perr |=> program_error_flag && !op_in_progress)
      else $error("program error not flagged");
   a_werr_sets: assert property (
      set_werr |=> protect_error_flag && !arr_req.prog)
      else $error("protect error not flagged");
   a_done_sets: assert property (
      op_in_progress && arr_rsp.done |=> op_done_flag)
      else $error("done flag not set at end");
   a_reset_values: assert property (disable iff (1'b0)
      sys_rst |=> !op_done_flag && !program_error_flag
         && wait_state_sel == WS_ZERO && !prefetch_enable)
      else $error("reset values wrong");
   a_w1c_done: assert property (
      wr_status && reg_wdata[DONE_BIT] && !set_done |=> !op_done_flag)
      else $error("done flag not cleared by write one");
   a_busy_falls_done: assert property (
      $fell(op_in_progress) |-> op_done_flag && $past(arr_rsp.done))
      else $error("busy fell without done flag");
   a_lock_blocks: assert property (
      lock_q && wr_ctrl && !pg_q |=> !pg_q)
      else $error("locked control register was written");
   a_err_irq: assert property (
      error_irq_enable_q && (program_error_flag || protect_error_flag) |-> flash_irq)
      else $error("error interrupt missing");
   a_done_irq: assert property (
      done_irq_enable_q && op_done_flag |-> flash_irq)
      else $error("done interrupt missing");

   c_unlock: cover property ($fell(lock_q));
   c_prog_done: cover property (prog_go ##[1:20] set_done);
   c_erase_done: cover property (erase_go ##[1:20] set_done);
   c_set_and_clear: cover property (set_done && wr_status
                                    && reg_wdata[DONE_BIT]);

endmodule : fcks_regs

//--- core/fcks_pkg.sv
package fcks_pkg;

   // Register offsets (byte addresses)
   localparam logic [7:0] OFF_ACCESS    = 8'h00;
   localparam logic [7:0] OFF_MAIN_KEY  = 8'h04;
   localparam logic [7:0] OFF_OPT_KEY   = 8'h08;
   localparam logic [7:0] OFF_STATUS    = 8'h0C;
   localparam logic [7:0] OFF_OP_CTRL   = 8'h10;
   localparam logic [7:0] OFF_TARGET    = 8'h14;
   localparam logic [7:0] OFF_OPT_STATE = 8'h1C;
   localparam logic [7:0] OFF_WRPROT    = 8'h20;
   localparam logic [7:0] OFF_IRQ_STAT  = 8'h24;
   localparam logic [7:0] OFF_IRQ_MASK  = 8'h28;

   // access_control fields
   localparam int WS_LSB   = 0;
   localparam int WS_MSB   = 2;
   localparam int PREFETCH_ENABLE_BIT = 4;
   localparam int PBST_BIT = 5;

   // operation_status fields (irq status and mask share the layout)
   localparam int BUSY_BIT = 0;
   localparam int PERR_BIT = 2;
   localparam int WERR_BIT = 4;
   localparam int DONE_BIT = 5;

   // operation_control fields
   localparam int PG_BIT     = 0;
   localparam int PER_BIT    = 1;
   localparam int MER_BIT    = 2;
   localparam int OBP_BIT    = 4;
   localparam int OBE_BIT    = 5;
   localparam int STA_BIT    = 6;
   localparam int LOCK_BIT   = 7;
   localparam int OBWEN_BIT  = 9;
   localparam int ERROR_IRQ_ENABLE_BIT  = 10;
   localparam int DONE_IRQ_ENABLE_BIT   = 12;
   localparam int OBLOAD_BIT = 13;

   // Reset values
   localparam logic [31:0] ACCESS_RST = 32'h0000_0000;
   localparam logic [31:0] STATUS_RST = 32'h0000_0000;
   localparam logic [31:0] TARGET_RST = 32'h0000_0000;
   localparam logic        LOCK_RST   = 1'b1;

   // Wait-state codes
   localparam logic [2:0] WS_ZERO = 3'h0;
   localparam logic [2:0] WS_ONE  = 3'h1;

   // Erased content of one flash halfword
   localparam logic [15:0] ERASED_HALF = 16'hFFFF;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_PROG,
      ST_ERASE
   } fcks_state_e;

   // Request towards the flash array
   typedef struct packed {
      logic        prog;
      logic        erase_page;
      logic        erase_mass;
      logic        opt_area;
      logic [31:0] addr;
      logic [15:0] wdata;
   } fcks_arr_req_s;

   // Answer from the flash array
   typedef struct packed {
      logic        done;
      logic        wp_hit;
      logic [15:0] old_data;
   } fcks_arr_rsp_s;

endpackage : fcks_pkg

//--- core/fcks_sticky.sv
module fcks_sticky
   import fcks_pkg::*;
#(
   parameter int W = 1
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         sys_rst,
   // Events and clears
   input  wire logic [W-1:0] set,
   input  wire logic [W-1:0] clr,
   output logic      [W-1:0] q
);

   // A set in the clear cycle wins so no event is lost
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         q <= '0;
      end else begin
         q <= (q & ~clr) | set;
      end
   end

endmodule : fcks_sticky

//--- testbench/fcks_flash_model.sv
module fcks_flash_model
   import fcks_pkg::*;
#(
   parameter int DLY = 4
) (
   // Clock and reset
   input  wire logic          clk,
   input  wire logic          sys_rst,
   // Array side
   input  wire fcks_arr_req_s arr_req,
   input  wire logic [31:0]   prog_addr,
   output fcks_arr_rsp_s      arr_rsp
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [15:0] mem [16];
   int          cnt_q;

   // Protected region is any address with bit 12 set
   // One driver for the whole answer struct
   assign arr_rsp = '{done:     (cnt_q == 1),
                      wp_hit:   prog_addr[12],
                      old_data: mem[prog_addr[4:1]]};

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cnt_q <= 0;
         foreach (mem[i]) mem[i] <= ERASED_HALF;
      end else begin
         if (cnt_q != 0) cnt_q <= cnt_q - 1;
         if (arr_req.prog || arr_req.erase_page || arr_req.erase_mass) begin
            cnt_q <= DLY;
         end
         if (arr_req.prog) mem[arr_req.addr[4:1]] <= arr_req.wdata;
         // Page or mass erase wipes the whole small model array
         if (arr_req.erase_page || arr_req.erase_mass) begin
            foreach (mem[i]) mem[i] <= ERASED_HALF;
         end
      end
   end
endmodule : fcks_flash_model

//--- testbench/fcks_regs_bench.sv
module fcks_regs_bench
   import fcks_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   localparam logic [31:0] K1 = 32'h1234_5678;
   localparam logic [31:0] K2 = 32'h9ABC_DEF0;

   logic          clk;
   logic          sys_rst;
   logic [7:0]    reg_addr;
   logic [31:0]   reg_wdata;
   logic          reg_we;
   logic          reg_re;
   logic [31:0]   reg_rdata;
   fcks_arr_req_s arr_req;
   fcks_arr_rsp_s arr_rsp;
   logic          prog_req;
   logic [31:0]   prog_addr;
   logic [15:0]   prog_data;
   logic [31:0]   opt_state;
   logic [31:0]   wrprot_state;
   logic [2:0]    wait_state_sel;
   logic          prefetch_enable;
   logic          prefetch_state;
   logic          option_load;
   logic          flash_irq;
   int            failures;
   int            comparisons;

   fcks_regs #(.KEY_FIRST(K1), .KEY_SECOND(K2)) dut (
      .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
      .reg_rdata(reg_rdata), .arr_req(arr_req), .arr_rsp(arr_rsp),
      .prog_req(prog_req), .prog_addr(prog_addr), .prog_data(prog_data),
      .opt_state(opt_state), .wrprot_state(wrprot_state),
      .wait_state_sel(wait_state_sel), .prefetch_enable(prefetch_enable),
      .prefetch_state(prefetch_state), .option_load(option_load),
      .flash_irq(flash_irq));

   fcks_flash_model #(.DLY(4)) array_model (
      .clk(clk), .sys_rst(sys_rst), .arr_req(arr_req),
      .prog_addr(prog_addr), .arr_rsp(arr_rsp));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic conclude;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : conclude

   task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic wr(logic [7:0] a, logic [31:0] d);
      @(posedge clk);
      reg_we    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_we <= 1'b0;
      #1;
   endtask : wr

   task automatic rd(logic [7:0] a, output logic [31:0] v);
      @(posedge clk);
      reg_re   <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_re <= 1'b0;
      #1;
      v = reg_rdata;
   endtask : rd

   task automatic rdc(logic [7:0] a, logic [31:0] exp);
      logic [31:0] v;
      rd(a, v);
      chk($sformatf("reg_%h", a), v, exp);
   endtask : rdc

   task automatic prog(logic [31:0] a, logic [15:0] d);
      @(posedge clk);
      prog_req  <= 1'b1;
      prog_addr <= a;
      prog_data <= d;
      @(posedge clk);
      prog_req <= 1'b0;
   endtask : prog

   // Poll busy with a bound so a stuck operation ends the run
   task automatic wait_idle;
      logic [31:0] v;
      for (int i = 0; i < 20; i++) begin
         rd(OFF_STATUS, v);
         if (v[BUSY_BIT] === 1'b0) return;
      end
      failures++;
      conclude();
   endtask : wait_idle

   initial begin
      #200us;
      failures++;
      conclude();
   end

   initial begin
      sys_rst      = 1'b1;
      reg_addr     = 8'h00;
      reg_wdata    = 32'h0000_0000;
      reg_we       = 1'b0;
      reg_re       = 1'b0;
      prog_req     = 1'b0;
      prog_addr    = 32'h0000_0000;
      prog_data    = 16'h0000;
      opt_state    = 32'hA5C3_0F12;
      wrprot_state = 32'h5A3C_F0E1;
      failures     = 0;
      comparisons  = 0;
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      rdc(OFF_ACCESS, 32'h0000_0000);
      rdc(OFF_STATUS, 32'h0000_0000);
      rdc(OFF_OP_CTRL, 32'h0000_0080);
      chk("irq", {31'h0, flash_irq}, 32'h0);
      wr(OFF_ACCESS, 32'h0000_0011);
      chk("ws", {29'h0, wait_state_sel}, 32'h1);
      chk("pf_en", {31'h0, prefetch_enable}, 32'h1);
      rdc(OFF_ACCESS, 32'h0000_0031);
      chk("pf_st", {31'h0, prefetch_state}, 32'h1);
      wr(OFF_ACCESS, 32'h0000_0000);
      chk("ws", {29'h0, wait_state_sel}, 32'h0);
      rdc(OFF_ACCESS, 32'h0000_0000);
      wr(OFF_OP_CTRL, 32'h0000_0001);
      rdc(OFF_OP_CTRL, 32'h0000_0080);
      wr(OFF_MAIN_KEY, K1);
      wr(OFF_MAIN_KEY, K2);
      rdc(OFF_OP_CTRL, 32'h0000_0000);
      rdc(OFF_MAIN_KEY, 32'h0000_0000);
      wr(OFF_OPT_KEY, K1);
      wr(OFF_OPT_KEY, K2);
      rdc(OFF_OP_CTRL, 32'h0000_0200);
      rdc(OFF_OPT_KEY, 32'h0000_0000);
      // Program an erased halfword
      wr(OFF_OP_CTRL, 32'h0000_0001);
      prog(32'h0000_0000, 16'h1234);
      rdc(OFF_STATUS, 32'h0000_0001);
      wait_idle();
      rdc(OFF_STATUS, 32'h0000_0020);
      chk("irq", {31'h0, flash_irq}, 32'h0);
      wr(OFF_OP_CTRL, 32'h0000_1001);
      chk("irq", {31'h0, flash_irq}, 32'h1);
      wr(OFF_STATUS, 32'h0000_0000);
      rdc(OFF_STATUS, 32'h0000_0020);
      wr(OFF_STATUS, 32'h0000_0020);
      rdc(OFF_STATUS, 32'h0000_0000);
      chk("irq", {31'h0, flash_irq}, 32'h0);
      rdc(OFF_IRQ_STAT, 32'h0000_0020);
      rdc(OFF_IRQ_STAT, 32'h0000_0000);
      // Same halfword again: not erased any more
      wr(OFF_IRQ_MASK, 32'h0000_0004);
      wr(OFF_OP_CTRL, 32'h0000_0001);
      prog(32'h0000_0000, 16'h5555);
      rdc(OFF_STATUS, 32'h0000_0004);
      chk("irq", {31'h0, flash_irq}, 32'h1);
      rdc(OFF_IRQ_STAT, 32'h0000_0004);
      chk("irq", {31'h0, flash_irq}, 32'h0);
      wr(OFF_OP_CTRL, 32'h0000_0401);
      chk("irq", {31'h0, flash_irq}, 32'h1);
      wr(OFF_STATUS, 32'h0000_0004);
      chk("irq", {31'h0, flash_irq}, 32'h0);
      prog(32'h0000_1000, 16'h0001);
      rdc(OFF_STATUS, 32'h0000_0010);
      chk("irq", {31'h0, flash_irq}, 32'h1);
      wr(OFF_STATUS, 32'h0000_0010);
      // Page erase brings back the erased value
      wr(OFF_TARGET, 32'h0000_0000);
      wr(OFF_OP_CTRL, 32'h0000_0042);
      rdc(OFF_STATUS, 32'h0000_0001);
      rdc(OFF_OP_CTRL, 32'h0000_0042);
      wait_idle();
      rdc(OFF_OP_CTRL, 32'h0000_0002);
      rdc(OFF_STATUS, 32'h0000_0020);
      wr(OFF_OP_CTRL, 32'h0000_0001);
      prog(32'h0000_0000, 16'h5555);
      wait_idle();
      rdc(OFF_STATUS, 32'h0000_0020);
      // Mass erase
      wr(OFF_STATUS, 32'h0000_0020);
      wr(OFF_OP_CTRL, 32'h0000_0044);
      rdc(OFF_STATUS, 32'h0000_0001);
      wait_idle();
      rdc(OFF_STATUS, 32'h0000_0020);
      wr(OFF_OP_CTRL, 32'h0000_2000);
      chk("obload", {31'h0, option_load}, 32'h1);
      // Reset in mid-run with flags and access bits set
      wr(OFF_ACCESS, 32'h0000_0011);
      sys_rst <= 1'b1;
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      rdc(OFF_ACCESS, 32'h0000_0000);
      rdc(OFF_STATUS, 32'h0000_0000);
      wr(OFF_MAIN_KEY, K1);
      wr(OFF_MAIN_KEY, K2);
      wr(OFF_OP_CTRL, 32'h0000_0080);
      rdc(OFF_OP_CTRL, 32'h0000_0080);
      wr(OFF_OP_CTRL, 32'h0000_2000);
      chk("obload", {31'h0, option_load}, 32'h0);
      rdc(OFF_OPT_STATE, opt_state);
      rdc(OFF_WRPROT, wrprot_state);
      rdc(8'h30, 32'h0000_0000);
      conclude();
   end
endmodule : fcks_regs_bench
